/* File: src/can_buf_pkg.sv */
// shared widths, depths and field positions for the can message buffer block
package can_buf_pkg;
	localparam int ID_W       = 29;
	localparam int DLC_W      = 4;
	localparam int DATA_W     = 64;
	localparam int TAG_W      = 8;
	localparam int TIME_W     = 16;
	localparam int NUM_FLT    = 8;
	localparam int HIT_W      = 3;
	localparam int KEY_W      = ID_W + 16;
	localparam int TX_DEPTH   = 8;
	localparam int RX_DEPTH   = 8;
	localparam int HIST_DEPTH = 8;
	localparam int MAX_BYTES  = 8;
	// transmit word: {ide, id, dlc, data, tag}
	localparam int TX_W       = 1 + ID_W + DLC_W + DATA_W + TAG_W;
	// history word: {tag, time}
	localparam int HIST_W     = TAG_W + TIME_W;
	// receive word: {ide, hit, id, dlc, data, time}
	localparam int RX_W       = 1 + HIT_W + ID_W + DLC_W + DATA_W + TIME_W;
	// first read byte: ide flag and accepting filter index
	localparam int HDR_IDE_BIT = 7;
	localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;
	localparam logic [DLC_W-1:0]  DLC_FULL = 4'h8;
endpackage : can_buf_pkg

/* File: src/can_tx_rx_fifo_filter.sv */
// transmit fifo, transmit history, acceptance filters and receive fifo of a can controller
//
// Behaviour
// - one-shot failure: no retry, message stays queued
// - transmit fifo holds eight complete messages
// - sending enabled by pin or control bit
// - enabled: send all queued messages back-to-back
// - enable or single-send moves next into buffer
// - halting finishes current message, sends no more
// - each success adds a history entry while the history fifo has room
// - history entry holds message tag and time
// - filter writes accepted only in initialization
// - reset leaves filters and masks untouched
// - filter enable off: store every valid frame
// - eight filters on id plus two bytes
// - mask one compares bit, zero ignores it
// - receive fifo holds eight accepted messages
// - sixteen-bit time tag attached after acknowledge
// - read with or without time tag
// - first byte: format flag and filter index
// - short frames read with zero-padded data bytes
// - without one-shot, failed message retried automatically while sending is enabled
`timescale 1ns/100ps
module can_tx_rx_fifo_filter
	import can_buf_pkg::*;
(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          link_clk_i,
	// control bits
	input  wire logic                          transmit_enable_ctl_i,
	input  wire logic                          transmit_enable_n_i,
	input  wire logic                          send_single_message_i,
	input  wire logic                          one_shot_mode_i,
	input  wire logic                          filter_bank_enable_i,
	input  wire logic                          init_mode_i,
	// transmit fifo loading
	input  wire logic                          tx_load_valid_i,
	input  wire logic                          tx_load_ide_i,
	input  wire logic [can_buf_pkg::ID_W-1:0]  tx_load_id_i,
	input  wire logic [can_buf_pkg::DLC_W-1:0] tx_load_dlc_i,
	input  wire logic [can_buf_pkg::DATA_W-1:0] tx_load_data_i,
	input  wire logic [can_buf_pkg::TAG_W-1:0] tx_load_tag_i,
	output logic                               tx_load_ready_o,
	input  wire logic                          tx_clear_i,
	// protocol engine, transmit side
	input  wire logic                          bus_idle_i,
	output logic                               tx_start_o,
	output logic                               tx_busy_o,
	output logic                               tx_held_o,
	output logic                               tx_ide_o,
	output logic [can_buf_pkg::ID_W-1:0]       tx_id_o,
	output logic [can_buf_pkg::DLC_W-1:0]      tx_dlc_o,
	output logic [can_buf_pkg::DATA_W-1:0]     tx_data_o,
	input  wire logic                          tx_ok_i,
	input  wire logic                          tx_lost_i,
	input  wire logic                          tx_err_i,
	// transmit history
	output logic                               hist_valid_o,
	output logic [can_buf_pkg::TAG_W-1:0]      hist_tag_o,
	output logic [can_buf_pkg::TIME_W-1:0]     hist_time_o,
	input  wire logic                          hist_ready_i,
	// filter and mask programming
	input  wire logic                          flt_wr_i,
	input  wire logic                          flt_is_mask_i,
	input  wire logic [can_buf_pkg::HIT_W-1:0] flt_sel_i,
	input  wire logic [can_buf_pkg::KEY_W-1:0] flt_data_i,
	// protocol engine, receive side
	input  wire logic                          rx_valid_i,
	input  wire logic                          rx_ide_i,
	input  wire logic [can_buf_pkg::ID_W-1:0]  rx_id_i,
	input  wire logic [can_buf_pkg::DLC_W-1:0] rx_dlc_i,
	input  wire logic [can_buf_pkg::DATA_W-1:0] rx_data_i,
	// received message read
	input  wire logic                          rx_read_time_i,
	output logic                               rx_out_valid_o,
	input  wire logic                          rx_out_ready_i,
	output logic [7:0]                         rx_out_hdr_o,
	output logic [can_buf_pkg::ID_W-1:0]       rx_out_id_o,
	output logic [can_buf_pkg::DLC_W-1:0]      rx_out_dlc_o,
	output logic [can_buf_pkg::DATA_W-1:0]     rx_out_data_o,
	output logic [can_buf_pkg::TIME_W-1:0]     rx_out_time_o,
	output logic                               rx_overflow_o
);
	import can_buf_pkg::*;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_WAIT,
		TX_SEND,
		TX_HOLD
	} tx_state_t;

	// ---------------- pin and link synchronisers ----------------
	logic link_meta;
	logic link_sync;
	logic link_prev;
	logic ten_meta;
	logic ten_sync;

	// link chain runs through reset, so a high link clock gives no false edge at release
	always_ff @(posedge clk_i) begin
		link_meta <= link_clk_i;
		link_sync <= link_meta;
		link_prev <= link_sync;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ten_meta <= 1'b1;
			ten_sync <= 1'b1;
		end else begin
			ten_meta <= transmit_enable_n_i;
			ten_sync <= ten_meta;
		end
	end

	wire link_tick = link_sync && !link_prev;

	// free running time tag counter, one step per link clock rising edge
	logic [TIME_W-1:0] time_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			time_cnt <= TIME_RST;
		else if (link_tick)
			time_cnt <= time_cnt + 1'b1;
	end

	// ---------------- transmit fifo ----------------
	logic            txf_ready;
	logic            txf_valid;
	logic [TX_W-1:0] txf_head;
	logic            txf_pop;

	msg_fifo #(
		.WIDTH (TX_W),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (tx_clear_i),
		.in_valid_i  (tx_load_valid_i),
		.in_data_i   ({tx_load_ide_i, tx_load_id_i, tx_load_dlc_i, tx_load_data_i, tx_load_tag_i}),
		.in_ready_o  (txf_ready),
		.out_valid_o (txf_valid),
		.out_data_o  (txf_head),
		.out_ready_i (txf_pop)
	);

	assign tx_load_ready_o = txf_ready;

	// ---------------- transmit sequencer ----------------
	tx_state_t        tx_state;
	tx_state_t        next_tx_state;
	logic             single_pend;
	logic [TAG_W-1:0] cur_tag;

	// pin low acts as the enable bit
	wire pin_enable  = !ten_sync;
	wire send_enable = transmit_enable_ctl_i || pin_enable;
	// enable or a pending single send fetches the next message
	wire fetch       = txf_valid && (send_enable || single_pend);
	wire tx_fail     = tx_lost_i || tx_err_i;

	// the head stays in the fifo until success, so a one-shot failure leaves it queued
	assign txf_pop = (tx_state == TX_SEND) && tx_ok_i;

	always_comb begin
		next_tx_state = tx_state;
		case (tx_state)
			TX_IDLE: begin
				// queued messages go out one after another
				if (fetch)
					next_tx_state = TX_WAIT;
			end
			TX_WAIT: begin
				// a halt before start leaves the rest unsent
				if (!send_enable && !single_pend)
					next_tx_state = TX_IDLE;
				else if (bus_idle_i)
					next_tx_state = TX_SEND;
			end
			TX_SEND: begin
				// once started the frame is always completed
				if (tx_ok_i)
					next_tx_state = TX_IDLE;
				else if (tx_fail && one_shot_mode_i)
					next_tx_state = TX_HOLD;
				// retry on the next free bus while sending is enabled
				else if (tx_fail)
					next_tx_state = TX_WAIT;
			end
			TX_HOLD: begin
				next_tx_state = TX_HOLD;
			end
			default: begin
				next_tx_state = TX_IDLE;
			end
		endcase
	end

	wire start_now = (tx_state == TX_WAIT) && (next_tx_state == TX_SEND);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state <= TX_IDLE;
		end else if (tx_clear_i && tx_state != TX_SEND) begin
			// reset aside, clearing the queue is the only way out of a held one-shot message
			tx_state <= TX_IDLE;
		end else begin
			tx_state <= next_tx_state;
		end
	end

	// single send request lasts until one frame has been started
	always_ff @(posedge clk_i) begin
		if (rst_i)
			single_pend <= 1'b0;
		else if (send_single_message_i)
			single_pend <= 1'b1;
		else if (start_now || tx_clear_i)
			single_pend <= 1'b0;
	end

	// transmit buffer, loaded from the fifo head on fetch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_ide_o  <= 1'b0;
			tx_id_o   <= '0;
			tx_dlc_o  <= '0;
			tx_data_o <= '0;
			cur_tag   <= '0;
		end else if (tx_state == TX_IDLE && fetch) begin
			{tx_ide_o, tx_id_o, tx_dlc_o, tx_data_o, cur_tag} <= txf_head;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_start_o <= 1'b0;
			tx_busy_o  <= 1'b0;
			tx_held_o  <= 1'b0;
		end else begin
			tx_start_o <= start_now;
			tx_busy_o  <= (next_tx_state == TX_SEND);
			tx_held_o  <= (next_tx_state == TX_HOLD) && !tx_clear_i;
		end
	end

	// ---------------- transmit history ----------------
	// each success pushes one entry
	wire hist_push = txf_pop;

	// entry pairs the message tag with the time tag
	msg_fifo #(
		.WIDTH (HIST_W),
		.DEPTH (HIST_DEPTH)
	) u_hist_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (1'b0),
		.in_valid_i  (hist_push),
		.in_data_i   ({cur_tag, time_cnt}),
		.in_ready_o  (),
		.out_valid_o (hist_valid_o),
		.out_data_o  ({hist_tag_o, hist_time_o}),
		.out_ready_i (hist_ready_i)
	);

	// ---------------- acceptance filters ----------------
	// no reset term, contents survive a device reset
	logic [KEY_W-1:0] flt_val  [NUM_FLT];
	logic [KEY_W-1:0] flt_mask [NUM_FLT];

	// writes only land in initialization mode
	wire flt_we = flt_wr_i && init_mode_i;

	always_ff @(posedge clk_i) begin
		if (flt_we && !flt_is_mask_i)
			flt_val[flt_sel_i] <= flt_data_i;
		if (flt_we && flt_is_mask_i)
			flt_mask[flt_sel_i] <= flt_data_i;
	end

	// key is the identifier plus the first two data bytes
	wire [KEY_W-1:0] rx_key = {rx_id_i, rx_data_i[DATA_W-1 -: 16]};
	wire [NUM_FLT-1:0] hit;

	genvar g;
	generate
		for (g = 0; g < NUM_FLT; g = g + 1) begin : g_flt
			assign hit[g] = ((rx_key ^ flt_val[g]) & flt_mask[g]) == '0;
		end
	endgenerate

	// lowest numbered matching filter is reported
	logic [HIT_W-1:0] hit_idx;

	always_comb begin
		hit_idx = '0;
		for (int i = NUM_FLT - 1; i >= 0; i--) begin
			if (hit[i])
				hit_idx = HIT_W'(i);
		end
	end

	// filtering off stores every valid frame
	// filtering on drops frames no filter matches
	wire accept = !filter_bank_enable_i || (|hit);

	// bytes beyond the length code are forced to zero
	logic [DATA_W-1:0] data_pad;

	always_comb begin
		data_pad = '0;
		for (int b = 0; b < MAX_BYTES; b++) begin
			if (b < int'(rx_dlc_i))
				data_pad[DATA_W-1-8*b -: 8] = rx_data_i[DATA_W-1-8*b -: 8];
		end
	end

	wire [DLC_W-1:0] rx_dlc_lim = (rx_dlc_i > DLC_FULL) ? DLC_FULL : rx_dlc_i;

	// ---------------- receive fifo ----------------
	logic            rxf_valid;
	logic [RX_W-1:0] rxf_head;
	logic [3:0]      rx_unread;
	wire             rx_room = rx_unread < 4'(RX_DEPTH);
	wire             rx_push = rx_valid_i && accept;
	wire             rx_take = rx_push && rx_room;
	wire             rx_pop  = rx_out_valid_o && rx_out_ready_i;
	wire             rxo_load = rxf_valid && (!rx_out_valid_o || rx_out_ready_i);

	// read stage counts toward depth, so eight unread frames fill the store
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rx_unread <= '0;
		else
			rx_unread <= rx_unread + 4'(rx_take) - 4'(rx_pop);
	end

	// time tag captured as the valid frame arrives
	msg_fifo #(
		.WIDTH (RX_W),
		.DEPTH (RX_DEPTH)
	) u_rx_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (1'b0),
		.in_valid_i  (rx_take),
		.in_data_i   ({rx_ide_i, hit_idx, rx_id_i, rx_dlc_lim, data_pad, time_cnt}),
		.in_ready_o  (),
		.out_valid_o (rxf_valid),
		.out_data_o  (rxf_head),
		.out_ready_i (rxo_load)
	);

	// read stage: header byte and optional time tag formed here
	wire             h_ide = rxf_head[RX_W-1];
	wire [HIT_W-1:0] h_hit = rxf_head[RX_W-2 -: HIT_W];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_out_valid_o <= 1'b0;
			rx_out_hdr_o   <= '0;
			rx_out_id_o    <= '0;
			rx_out_dlc_o   <= '0;
			rx_out_data_o  <= '0;
			rx_out_time_o  <= '0;
		end else if (rxo_load) begin
			rx_out_valid_o <= 1'b1;
			// format flag on top, filter index in the low bits
			rx_out_hdr_o   <= {h_ide, {(HDR_IDE_BIT-HIT_W){1'b0}}, h_hit};
			{rx_out_id_o, rx_out_dlc_o, rx_out_data_o} <= rxf_head[TIME_W +: ID_W+DLC_W+DATA_W];
			// time tag given only for the timed read
			rx_out_time_o  <= rx_read_time_i ? rxf_head[TIME_W-1:0] : '0;
		end else if (rx_out_ready_i) begin
			rx_out_valid_o <= 1'b0;
		end
	end

	// sticky: a frame arrived with no room and was lost
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rx_overflow_o <= 1'b0;
		else if (rx_push && !rx_room)
			rx_overflow_o <= 1'b1;
	end
endmodule : can_tx_rx_fifo_filter

/* File: src/msg_fifo.sv */
// generic message fifo with registered head and registered space flag
`timescale 1ns/100ps
module msg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      cnt;
	logic [AW:0]      next_cnt;
	logic             next_out_valid;
	wire              push = in_valid_i && in_ready_o;
	// head register counts toward depth, so total capacity is exactly DEPTH
	wire              load = (cnt != '0) && (!out_valid_o || out_ready_i);

	assign next_cnt       = cnt + (AW+1)'(push) - (AW+1)'(load);
	assign next_out_valid = load ? 1'b1 : (out_ready_i ? 1'b0 : out_valid_o);

	always_ff @(posedge clk_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			cnt         <= '0;
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
			in_ready_o  <= 1'b1;
		end else begin
			wr_ptr      <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr      <= load ? rd_ptr + 1'b1 : rd_ptr;
			cnt         <= next_cnt;
			out_valid_o <= next_out_valid;
			if (load)
				out_data_o <= mem[rd_ptr];
			in_ready_o  <= (int'(next_cnt) + int'(next_out_valid)) < DEPTH;
		end
	end
endmodule : msg_fifo

/* File: testbench/can_engine_model.sv */
// protocol engine stand-in: holds the bus per started frame and reports a result
`timescale 1ns/100ps
module can_engine_model (
	input  wire logic       clk_i,
	input  wire logic       tx_start_i,
	input  wire logic [1:0] result_i,
	output logic            bus_idle_o,
	output logic            tx_ok_o,
	output logic            tx_lost_o,
	output logic            tx_err_o
);
	int   remain = 0;
	logic slow   = 0;
	initial begin
		bus_idle_o = 1;
		{tx_ok_o, tx_lost_o, tx_err_o} = 3'b000;
	end
	// short and long frames alternate so both answer speeds occur
	always @(posedge clk_i) begin
		{tx_ok_o, tx_lost_o, tx_err_o} <= 3'b000;
		if (tx_start_i) begin
			remain <= slow ? 14 : 2;
			slow <= !slow;
			bus_idle_o <= 0;
		end else if (remain == 1) begin
			remain <= 0;
			bus_idle_o <= 1;
			{tx_ok_o, tx_lost_o, tx_err_o} <= {result_i == 2'd0, result_i == 2'd1, result_i == 2'd2};
		end else if (remain > 1) begin
			remain <= remain - 1;
		end
	end
endmodule : can_engine_model

/* File: testbench/can_tx_rx_fifo_filter_props.sv */
// port assertions for the message buffer block
`timescale 1ns/100ps
module can_tx_rx_fifo_filter_props
	import can_buf_pkg::*;
(
	input wire logic                           clk_i,
	input wire logic                           rst_i,
	input wire logic                           bus_idle_i,
	input wire logic                           one_shot_mode_i,
	input wire logic                           tx_start_o,
	input wire logic                           tx_busy_o,
	input wire logic                           tx_held_o,
	input wire logic                           tx_ok_i,
	input wire logic                           tx_lost_i,
	input wire logic                           tx_err_i,
	input wire logic                           hist_valid_o,
	input wire logic                           rx_out_valid_o,
	input wire logic                           rx_out_ready_i,
	input wire logic [7:0]                     rx_out_hdr_o,
	input wire logic [can_buf_pkg::DLC_W-1:0]  rx_out_dlc_o,
	input wire logic [can_buf_pkg::DATA_W-1:0] rx_out_data_o,
	input wire logic                           rx_overflow_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_start_idle: assert property (tx_start_o |-> $past(bus_idle_i))
		else $error("start without free bus");
	a_start_busy: assert property (tx_start_o |-> tx_busy_o && !tx_held_o)
		else $error("start without busy");
	a_ok_ends_busy: assert property (tx_busy_o && tx_ok_i |=> !tx_busy_o)
		else $error("busy after success");
	a_ok_adds_hist: assert property (tx_busy_o && tx_ok_i && !hist_valid_o |-> ##[1:4] hist_valid_o)
		else $error("no history entry");
	a_fail_holds: assert property (tx_busy_o && (tx_lost_i || tx_err_i) && one_shot_mode_i
		|-> ##[1:2] tx_held_o)
		else $error("one-shot failure not held");
	a_held_no_start: assert property (tx_held_o |-> !tx_start_o)
		else $error("start while held");
	a_retry_free: assert property (tx_busy_o && tx_lost_i && !one_shot_mode_i |=> !tx_held_o)
		else $error("held without one-shot");
	a_hdr_spare: assert property (rx_out_valid_o |-> rx_out_hdr_o[6:3] == 4'h0)
		else $error("header spare bits set");
	a_dlc_clamp: assert property (rx_out_valid_o |-> rx_out_dlc_o <= DLC_FULL)
		else $error("length above eight");
	a_pad_zero: assert property (rx_out_valid_o |-> (rx_out_data_o << {rx_out_dlc_o, 3'b000}) == '0)
		else $error("padding not zero");
	a_rx_hold: assert property (rx_out_valid_o && !rx_out_ready_i
		|=> rx_out_valid_o && $stable(rx_out_data_o))
		else $error("read stage changed");
	a_ovf_sticky: assert property (rx_overflow_o |=> rx_overflow_o)
		else $error("overflow flag dropped");

	cover property ($rose(tx_held_o));
	cover property (rx_overflow_o);
	cover property (rx_out_valid_o && rx_out_hdr_o[2:0] != 3'h0);
endmodule : can_tx_rx_fifo_filter_props

/* File: testbench/can_tx_rx_fifo_filter_tb.sv */
// self-checking bench for the message buffer and filter block
`timescale 1ns/100ps
module can_tx_rx_fifo_filter_tb;
	import can_buf_pkg::*;
	logic clk_i = 0, rst_i = 1, link_clk_i = 0, hist_ready_i = 1, tx_clear_i = 0;
	logic transmit_enable_ctl_i = 0, transmit_enable_n_i = 1, send_single_message_i = 0;
	logic one_shot_mode_i = 0, filter_bank_enable_i = 0, init_mode_i = 0;
	logic tx_load_valid_i = 0, tx_load_ide_i = 0, tx_load_ready_o;
	logic [ID_W-1:0]   tx_load_id_i = '0, tx_id_o, rx_id_i = '0, rx_out_id_o;
	logic [DLC_W-1:0]  tx_load_dlc_i = '0, tx_dlc_o, rx_dlc_i = '0, rx_out_dlc_o;
	logic [DATA_W-1:0] tx_load_data_i = '0, tx_data_o, rx_data_i = '0, rx_out_data_o;
	logic [TAG_W-1:0]  tx_load_tag_i = '0, hist_tag_o;
	logic bus_idle_i, tx_start_o, tx_busy_o, tx_held_o, tx_ide_o, tx_ok_i, tx_lost_i, tx_err_i;
	logic hist_valid_o, flt_wr_i = 0, flt_is_mask_i = 0, rx_valid_i = 0, rx_ide_i = 0;
	logic [HIT_W-1:0]  flt_sel_i = '0;
	logic [KEY_W-1:0]  flt_data_i = '0, flt[8], msk[8];
	logic rx_read_time_i = 0, rx_out_valid_o, rx_out_ready_i = 0, rx_overflow_o;
	logic [7:0]        rx_out_hdr_o;
	logic [TIME_W-1:0] hist_time_o, rx_out_time_o, lk_cnt = '0, last_ht = '0;
	logic [1:0]        fkind = 0;
	logic [TX_W-1:0]   txq[$];
	logic [TAG_W-1:0]  histq[$];
	logic [104:0]      rxq[$];
	logic [TIME_W-1:0] rxt[$];
	int seed = 81, err_total = 0, comparisons = 0, starts = 0, hist_n = 0, fails = 0;

	can_tx_rx_fifo_filter u_can_tx_rx_fifo_filter (.*);
	can_engine_model u_can_engine_model (.clk_i(clk_i), .tx_start_i(tx_start_o),
		.result_i(fails > 0 ? fkind : 2'd0), .bus_idle_o(bus_idle_i), .tx_ok_o(tx_ok_i),
		.tx_lost_o(tx_lost_i), .tx_err_o(tx_err_i));

	always #20 clk_i = ~clk_i;
	initial begin
		#3;
		forever #160 link_clk_i = ~link_clk_i;
	end
	always @(posedge link_clk_i) lk_cnt <= rst_i ? 16'h0 : lk_cnt + 16'h1;

	task automatic check(input string what, input logic [127:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic limit(input int n, lim);
		if (n >= lim) begin
			check("wait_bound", 1, 0);
			print_verdict();
		end
	endtask : limit

	task automatic do_reset();
		rst_i <= 1;
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		rxq.delete();
		rxt.delete();
		last_ht = '0;
	endtask : do_reset

	task automatic pulse_single();
		send_single_message_i <= 1;
		@(posedge clk_i);
		send_single_message_i <= 0;
	endtask : pulse_single

	// one frame per held load strobe
	task automatic load();
		logic [TX_W-1:0] w;
		int n;
		w = TX_W'({$random(seed), $random(seed), $random(seed), $random(seed)});
		{tx_load_ide_i, tx_load_id_i, tx_load_dlc_i, tx_load_data_i, tx_load_tag_i} <= w;
		tx_load_valid_i <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (tx_load_ready_o) break;
		end
		limit(n, 50);
		txq.push_back(w);
	endtask : load

	function automatic logic [KEY_W-1:0] rkey();
		return KEY_W'({$random(seed), $random(seed)});
	endfunction : rkey

	function automatic int hit_of(input logic [KEY_W-1:0] key);
		for (int k = 0; k < NUM_FLT; k++)
			if (((key ^ flt[k]) & msk[k]) == '0) return k;
		return -1;
	endfunction : hit_of

	task automatic rx_send(input logic [KEY_W-1:0] key, input logic [DLC_W-1:0] dlc);
		logic [DATA_W-1:0] d;
		logic [DLC_W-1:0] de;
		int h;
		d = {key[15:0], 16'($random(seed)), 32'($random(seed))};
		de = dlc > DLC_FULL ? DLC_FULL : dlc;
		h = filter_bank_enable_i ? hit_of(key) : 0;
		{rx_valid_i, rx_ide_i, rx_id_i, rx_dlc_i, rx_data_i} <= {1'b1, d[0], key[KEY_W-1:16], dlc, d};
		@(posedge clk_i);
		rx_valid_i <= 0;
		if (h >= 0 && rxq.size() < RX_DEPTH) begin
			rxq.push_back({d[0], 4'h0, 3'(h), key[KEY_W-1:16], de,
				d & ~(64'hffffffffffffffff >> {de, 3'b000})});
			rxt.push_back(lk_cnt);
		end
		repeat (4) @(posedge clk_i);
	endtask : rx_send

	always @(posedge clk_i) if (!rst_i) begin
		if (tx_start_o) begin
			starts++;
			check("tx_msg", {tx_ide_o, tx_id_o, tx_dlc_o, tx_data_o}, txq.size() ? txq[0][TX_W-1:TAG_W] : '1);
		end
		if (tx_busy_o && tx_ok_i && txq.size() > 0) begin
			histq.push_back(txq[0][TAG_W-1:0]);
			void'(txq.pop_front());
		end
		if ((tx_lost_i || tx_err_i) && fails > 0) fails--;
		if (hist_valid_o && hist_ready_i) begin
			hist_n++;
			check("hist_tag", hist_tag_o, histq.size() ? histq.pop_front() : '1);
			check("hist_time", hist_time_o >= last_ht, 1);
			last_ht = hist_time_o;
		end
		if (rx_out_valid_o && rx_out_ready_i) begin
			check("rx_msg", {rx_out_hdr_o, rx_out_id_o, rx_out_dlc_o, rx_out_data_o}, rxq.size() ? rxq.pop_front() : '1);
			check("rx_time", rx_read_time_i ? (rx_out_time_o <= rxt[0] && rx_out_time_o + 2 >= rxt[0]) : rx_out_time_o == 16'h0, 1);
			void'(rxt.pop_front());
		end
	end

	initial begin
		int n, k;
		logic [KEY_W-1:0] key;
		do_reset();
		check("reset_out", {tx_load_ready_o, tx_start_o, tx_held_o, hist_valid_o, rx_out_valid_o, rx_overflow_o}, 6'h20);
		for (int i = 0; i < 8; i++) load();
		tx_load_valid_i <= 0;
		repeat (3) @(posedge clk_i);
		check("tx_full", {tx_load_ready_o, 8'(starts)}, 9'h000);
		fails = 1;
		fkind = 2'd1;
		transmit_enable_n_i <= 0;
		for (n = 0; n < 3000 && txq.size() > 0; n++) @(posedge clk_i);
		limit(n, 3000);
		repeat (6) @(posedge clk_i);
		check("sent_all", {8'(starts), 8'(hist_n)}, {8'd9, 8'd8});
		transmit_enable_n_i <= 1;
		for (int i = 0; i < 3; i++) load();
		tx_load_valid_i <= 0;
		starts = 0;
		transmit_enable_ctl_i <= 1;
		for (n = 0; n < 200 && !tx_busy_o; n++) @(posedge clk_i);
		limit(n, 200);
		transmit_enable_ctl_i <= 0;
		repeat (60) @(posedge clk_i);
		check("halt", {8'(starts), 8'(txq.size())}, {8'd1, 8'd2});
		starts = 0;
		pulse_single();
		repeat (60) @(posedge clk_i);
		check("single", {8'(starts), 8'(txq.size())}, {8'd1, 8'd1});
		starts = 0;
		fails = 1;
		fkind = 2'd2;
		one_shot_mode_i <= 1;
		pulse_single();
		repeat (40) @(posedge clk_i);
		transmit_enable_ctl_i <= 1;
		repeat (40) @(posedge clk_i);
		check("one_shot", {tx_held_o, 8'(starts), 8'(txq.size())}, {1'b1, 8'd1, 8'd1});
		tx_clear_i <= 1;
		@(posedge clk_i);
		tx_clear_i <= 0;
		txq.delete();
		load();
		tx_load_valid_i <= 0;
		repeat (60) @(posedge clk_i);
		check("reload", {tx_held_o, 8'(starts), 8'(txq.size())}, {1'b0, 8'd2, 8'd0});
		transmit_enable_ctl_i <= 0;
		one_shot_mode_i <= 0;
		rx_out_ready_i <= 1;
		rx_read_time_i <= 1;
		@(posedge clk_i);
		for (int i = 0; i < 6; i++) rx_send(rkey(), DLC_W'($random(seed)));
		repeat (10) @(posedge clk_i);
		rx_read_time_i <= 0;
		for (int i = 0; i < 4; i++) rx_send(rkey(), DLC_W'(i * 5));
		// random format flags, lengths 0 and 5 zero-padded, 10 and 15 clamped
		// program every filter and mask, then one write outside initialization
		init_mode_i <= 1;
		flt_wr_i <= 1;
		for (int i = 0; i < 16; i++) begin
			key = rkey();
			if (i % 2 == 1) key = key | KEY_W'(32'hffff00ff);
			if (i % 2 == 1) msk[i / 2] = key;
			else flt[i / 2] = key;
			{flt_is_mask_i, flt_sel_i, flt_data_i} <= {1'(i % 2), 3'(i / 2), key};
			@(posedge clk_i);
		end
		init_mode_i <= 0;
		{flt_is_mask_i, flt_sel_i, flt_data_i} <= {1'b0, 3'h0, ~flt[0]};
		@(posedge clk_i);
		flt_wr_i <= 0;
		filter_bank_enable_i <= 1;
		do_reset();
		for (int i = 0; i < 16; i++) begin
			k = $unsigned($random(seed)) % NUM_FLT;
			key = (i % 2 == 1) ? rkey() : (flt[k] & msk[k]) | (rkey() & ~msk[k]);
			rx_send(key, DLC_FULL);
		end
		filter_bank_enable_i <= 0;
		repeat (10) @(posedge clk_i);
		check("rx_empty", {rx_out_valid_o, 4'(rxq.size())}, 5'h0);
		rx_out_ready_i <= 0;
		for (int i = 0; i < 9; i++) rx_send(rkey(), DLC_FULL);
		check("overflow", {rx_overflow_o, 4'(rxq.size())}, {1'b1, 4'd8});
		rx_out_ready_i <= 1;
		repeat (40) @(posedge clk_i);
		check("drained", {rx_out_valid_o, 4'(rxq.size())}, 5'h0);
		print_verdict();
	end
endmodule : can_tx_rx_fifo_filter_tb

bind can_tx_rx_fifo_filter can_tx_rx_fifo_filter_props u_can_tx_rx_fifo_filter_props (.*);
